/* vlsr_params.svh */
// Operation
// - A setpoint write above the channel's upper limit is a violation event.
// - A violation sets the none-of-the-above bit of the summary status byte.
// - A violation sets the output-voltage bit of the status word.
// - A violation sets the limit warning bit of that channel's output status.
// - A violation drives the alert line as the alert mask allows.
// - The upper limit is two bytes read in the current output format.
// - Page 0 addresses channel 1, page 1 addresses channel 2.
// - Page 81 writes both channels' copies at once.
// - Writes to a slave-phase channel are stored but cause no behaviour.
// - Linear limit uses exponent 10111, minus nine, 1.953 mV per count.
// - Scale factor 1 accepts linear limit 307 to 768.
// - Scale factor 0.5 accepts linear limit 614 to 1536.
// - Scale factor 0.25 accepts linear limit 1229 to 3072.
// - Linear limit resets to 0x0300.
// - Voltage-ID limit resets to 0x00fb and accepts 0x0047 to 0x00fb.
// - Setpoint changes ramp toward the new target at the selected slew.
// - Slew field 2:0 selects 0.065 up to 1.953 mV/us.
// - Slew bits 15:3 ignore writes and read as zero.
// - Slew register resets to 0x0006, 0.977 mV/us.
// - Voltage-ID codes step 5 mV from 0.250 V at code 1; code 0 is off.
// - Format register takes only 0x17 linear or 0x21 voltage-ID.
`ifndef VLSR_PARAMS_SVH
`define VLSR_PARAMS_SVH

// ----------------------------------------------------------------
// Command codes and pages
// ----------------------------------------------------------------
`define CMD_CLEAR 8'h03
`define CMD_FMT 8'h20
`define CMD_SETPT 8'h21
`define CMD_LIMIT 8'h24
`define CMD_SLEW 8'h27
`define PAGE_CH1 8'h00
`define PAGE_CH2 8'h01
`define PAGE_ALL 8'h81

// ----------------------------------------------------------------
// Formats, ranges, resets
// ----------------------------------------------------------------
`define FMT_LINEAR 8'h17
`define FMT_VID 8'h21
`define LIN_EXP 5'h17
`define LIMIT_RST_LIN 16'h0300
`define LIMIT_RST_VID 16'h00fb
`define VID_LIMIT_MIN 16'h0047
`define SCALE_X1 3'h4
`define SCALE_X05 3'h2
`define SCALE_X025 3'h1
`define LIN_MIN_X1 16'h0133
`define LIN_MAX_X1 16'h0300
`define LIN_MIN_X05 16'h0266
`define LIN_MAX_X05 16'h0600
`define LIN_MIN_X025 16'h04cd
`define LIN_MAX_X025 16'h0c00
`define SETPT_RST_LIN 16'h0133
`define SETPT_RST_VID 16'h0047
`define SLEW_RST 16'h0006
`define SLEW_MSB 2

// ----------------------------------------------------------------
// Status bit positions
// ----------------------------------------------------------------
`define STS_BYTE_NOA_BIT 0
`define STS_WORD_VOUT_BIT 15
`define STS_VOUT_WARN_BIT 3

// ----------------------------------------------------------------
// Timing and slew steps in uV
// ----------------------------------------------------------------
`define CLK_PERIOD_NS 10
`define US_NS 1000
`define US_CYCLES (`US_NS / `CLK_PERIOD_NS)
`define LIN_STEP_UV 13'h07a1
`define VID_STEP_UV 13'h1388
`define RATE_UV_0 13'h0041
`define RATE_UV_1 13'h0062
`define RATE_UV_2 13'h008c
`define RATE_UV_3 13'h00f4
`define RATE_UV_4 13'h0146
`define RATE_UV_5 13'h01e8
`define RATE_UV_6 13'h03d1
`define RATE_UV_7 13'h07a1

`endif

/* vlsr_pkg.sv */
package vlsr_pkg;

    typedef enum logic [1:0] {
        RAMP_IDLE = 2'b00,
        RAMP_UP = 2'b01,
        RAMP_DOWN = 2'b10
    } vlsr_ramp_st_t;

    typedef struct packed {
        vlsr_ramp_st_t st;
        logic [6:0] us_cnt;
        logic [12:0] acc;
        logic [15:0] level;
    } vlsr_ramp_t;

    typedef struct packed {
        logic [1:0][15:0] limit;
        logic [1:0][2:0] slew;
        logic [1:0][15:0] target;
        logic [7:0] fmt;
        logic [1:0] warn;
        logic noa;
        logic vout_sum;
        logic alert;
        logic rd_valid;
        logic [15:0] rd_data;
    } vlsr_regs_t;

endpackage

/* vlsr_ramp_if.sv */
`timescale 1ns/1ps
interface vlsr_ramp_if;
    logic [15:0] target;
    logic [2:0] rate_sel;
    logic vid_mode;
    logic hold;
    logic [15:0] level;
    logic busy;
    modport ctrl (output target, output rate_sel, output vid_mode, output hold, input level, input busy);
    modport ramp (input target, input rate_sel, input vid_mode, input hold, output level, output busy);
endinterface

/* vlsr_ramp.sv */
`timescale 1ns/1ps
`include "vlsr_params.svh"
module vlsr_ramp
    import vlsr_pkg::*;
(
    input logic sys_clk, // System clock
    input logic rstn, // Async reset, active low
    vlsr_ramp_if.ramp rif // Target in, level out
);

    localparam logic [6:0] US_LAST = 7'(`US_CYCLES - 1);

    vlsr_ramp_t s;
    vlsr_ramp_t n;
    logic tick;
    logic [12:0] rate;
    logic [12:0] step;
    logic [12:0] sum;

    always_comb begin
        case (rif.rate_sel)
            3'h0: rate = `RATE_UV_0;
            3'h1: rate = `RATE_UV_1;
            3'h2: rate = `RATE_UV_2;
            3'h3: rate = `RATE_UV_3;
            3'h4: rate = `RATE_UV_4;
            3'h5: rate = `RATE_UV_5;
            3'h6: rate = `RATE_UV_6;
            default: rate = `RATE_UV_7;
        endcase
    end

    assign step = rif.vid_mode ? `VID_STEP_UV : `LIN_STEP_UV;
    assign tick = (s.us_cnt == US_LAST);
    assign sum = 13'(s.acc + rate);

    always_comb begin
        n = s;
        n.us_cnt = tick ? 7'h00 : 7'(s.us_cnt + 7'h01);
        unique case (s.st)
            RAMP_IDLE: begin
                n.acc = 13'h0000;
                if (!rif.hold && rif.target > s.level) begin
                    n.st = RAMP_UP;
                end else if (!rif.hold && rif.target < s.level) begin
                    n.st = RAMP_DOWN;
                end
            end
            RAMP_UP: begin
                if (rif.hold || s.level >= rif.target) begin
                    n.st = RAMP_IDLE;
                end else if (tick) begin
                    n.acc = (sum >= step) ? 13'(sum - step) : sum;
                    n.level = (sum >= step) ? 16'(s.level + 16'h0001) : s.level;
                end
            end
            RAMP_DOWN: begin
                if (rif.hold || s.level <= rif.target) begin
                    n.st = RAMP_IDLE;
                end else if (tick) begin
                    n.acc = (sum >= step) ? 13'(sum - step) : sum;
                    n.level = (sum >= step) ? 16'(s.level - 16'h0001) : s.level;
                end
            end
            default: begin
                n.st = RAMP_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            s <= '0;
            s.level <= `SETPT_RST_LIN;
        end else begin
            s <= n;
        end
    end

    assign rif.level = s.level;
    assign rif.busy = (s.st != RAMP_IDLE);

    AST_RAMP_ONE_STEP: assert property (@(posedge sys_clk) disable iff (!rstn)
        (s.level != $past(s.level)) |-> ($past(s.st) != RAMP_IDLE) && $past(tick)) else $error("level moved off tick");
    AST_RAMP_HOLD: assert property (@(posedge sys_clk) disable iff (!rstn)
        rif.hold |=> $stable(s.level)) else $error("held ramp moved");

endmodule

/* vlsr_regs.sv */
`timescale 1ns/1ps
`include "vlsr_params.svh"
module vlsr_regs
    import vlsr_pkg::*;
(
    input logic sys_clk, // System clock, 100 MHz
    input logic rstn, // Async reset, active low
    input logic [7:0] cmd_code, // Command code of access
    input logic [7:0] page, // Current page value
    input logic wr_en, // Write strobe, one cycle
    input logic [15:0] wr_data, // Write data, two bytes
    input logic rd_en, // Read strobe, one cycle
    output logic [15:0] rd_data, // Read data
    output logic rd_valid, // Read data valid, one cycle
    input logic [5:0] scale_mant, // Feedback scale mantissa, 3 bits per channel
    input logic [1:0] slave_phase, // Channel runs as slave phase
    input logic [1:0] alert_mask, // Masks warning from alert per channel
    output logic [7:0] status_byte, // Summary status byte
    output logic [15:0] status_word, // Status word
    output logic [15:0] status_vout, // Output status, ch1 low byte
    output logic alert_n, // Alert line, active low
    output logic [31:0] vout_level, // Ramped setpoint, ch1 low half
    output logic [1:0] ramp_busy, // Ramp in progress per channel
    output logic [1:0] output_off // Voltage-ID code zero, no output
);

    vlsr_regs_t s;
    vlsr_regs_t n;
    logic is_vid;
    logic clr;
    logic fmt_ok;
    logic fmt_wr;
    logic rd_ch;
    logic [15:0] rd_mux;
    logic [1:0] sel;
    logic [1:0] lim_ok;
    logic [1:0] lim_wr;
    logic [1:0] slew_wr;
    logic [1:0] sp_wr;
    logic [1:0] over;
    logic [1:0] viol;
    logic [1:0] sp_ok;

    // ----------------------------------------------------------------
    // Linear limit range check
    // ----------------------------------------------------------------
    function automatic logic lin_ok(input logic [15:0] d, input logic [2:0] sc);
        logic ok;
        ok = 1'b0;
        case (sc)
            `SCALE_X1: ok = (d >= `LIN_MIN_X1) && (d <= `LIN_MAX_X1);
            `SCALE_X05: ok = (d >= `LIN_MIN_X05) && (d <= `LIN_MAX_X05);
            `SCALE_X025: ok = (d >= `LIN_MIN_X025) && (d <= `LIN_MAX_X025);
            default: ok = 1'b0;
        endcase
        return ok;
    endfunction

    // ----------------------------------------------------------------
    // Decode
    // ----------------------------------------------------------------
    assign is_vid = (s.fmt == `FMT_VID);
    assign clr = wr_en && (cmd_code == `CMD_CLEAR);
    assign fmt_ok = (wr_data[7:0] == `FMT_LINEAR) || (wr_data[7:0] == `FMT_VID);
    assign fmt_wr = wr_en && (cmd_code == `CMD_FMT) && fmt_ok;
    assign rd_ch = (page == `PAGE_CH2);

    generate
        for (genvar g = 0; g < 2; g++) begin : g_ch
            vlsr_ramp_if rif ();

            assign sel[g] = (page == ((g == 0) ? `PAGE_CH1 : `PAGE_CH2)) || (page == `PAGE_ALL);
            assign lim_ok[g] = is_vid ? ((wr_data >= `VID_LIMIT_MIN) && (wr_data <= `LIMIT_RST_VID))
                                      : lin_ok(wr_data, scale_mant[g*3 +: 3]);
            assign lim_wr[g] = wr_en && (cmd_code == `CMD_LIMIT) && sel[g] && lim_ok[g];
            assign slew_wr[g] = wr_en && (cmd_code == `CMD_SLEW) && sel[g];
            assign sp_wr[g] = wr_en && (cmd_code == `CMD_SETPT) && sel[g];
            assign over[g] = (wr_data > s.limit[g]);
            assign viol[g] = sp_wr[g] && over[g] && !slave_phase[g];
            assign sp_ok[g] = sp_wr[g] && (slave_phase[g] || !over[g]);

            assign rif.target = s.target[g];
            assign rif.rate_sel = s.slew[g];
            assign rif.vid_mode = is_vid;
            assign rif.hold = slave_phase[g];

            vlsr_ramp u_ramp (
                .sys_clk(sys_clk),
                .rstn(rstn),
                .rif(rif.ramp)
            );

            assign vout_level[g*16 +: 16] = rif.level;
            assign ramp_busy[g] = rif.busy;
            assign output_off[g] = is_vid && (rif.level == 16'h0000);
        end
    endgenerate

    // ----------------------------------------------------------------
    // Read mux
    // ----------------------------------------------------------------
    always_comb begin
        case (cmd_code)
            `CMD_LIMIT: rd_mux = s.limit[rd_ch];
            `CMD_SLEW: rd_mux = {13'h0000, s.slew[rd_ch]};
            `CMD_SETPT: rd_mux = s.target[rd_ch];
            `CMD_FMT: rd_mux = {8'h00, s.fmt};
            default: rd_mux = 16'h0000;
        endcase
    end

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        n = s;
        for (int i = 0; i < 2; i++) begin
            if (lim_wr[i]) begin
                n.limit[i] = wr_data;
            end
            if (slew_wr[i]) begin
                n.slew[i] = wr_data[`SLEW_MSB:0];
            end
            if (sp_ok[i]) begin
                n.target[i] = wr_data;
            end
            n.warn[i] = viol[i] | (s.warn[i] & ~clr);
        end
        if (fmt_wr && (wr_data[7:0] != s.fmt)) begin
            n.fmt = wr_data[7:0];
            for (int i = 0; i < 2; i++) begin
                n.limit[i] = (wr_data[7:0] == `FMT_VID) ? `LIMIT_RST_VID : `LIMIT_RST_LIN;
                n.target[i] = (wr_data[7:0] == `FMT_VID) ? `SETPT_RST_VID : `SETPT_RST_LIN;
            end
        end
        n.noa = (|viol) | (s.noa & ~clr);
        n.vout_sum = (|viol) | (s.vout_sum & ~clr);
        n.alert = |(n.warn & ~alert_mask);
        n.rd_valid = rd_en;
        if (rd_en) begin
            n.rd_data = rd_mux;
        end
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            s <= '0;
            s.limit[0] <= `LIMIT_RST_LIN;
            s.limit[1] <= `LIMIT_RST_LIN;
            s.slew[0] <= 3'(`SLEW_RST);
            s.slew[1] <= 3'(`SLEW_RST);
            s.target[0] <= `SETPT_RST_LIN;
            s.target[1] <= `SETPT_RST_LIN;
            s.fmt <= `FMT_LINEAR;
        end else begin
            s <= n;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    always_comb begin
        status_byte = 8'h00;
        status_byte[`STS_BYTE_NOA_BIT] = s.noa;
        status_word = {8'h00, status_byte};
        status_word[`STS_WORD_VOUT_BIT] = s.vout_sum;
        status_vout = 16'h0000;
        status_vout[`STS_VOUT_WARN_BIT] = s.warn[0];
        status_vout[8 + `STS_VOUT_WARN_BIT] = s.warn[1];
    end

    assign alert_n = ~s.alert;
    assign rd_data = s.rd_data;
    assign rd_valid = s.rd_valid;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rstn);

    sequence SEQ_VIOL0;
        wr_en && (cmd_code == `CMD_SETPT) && sel[0] && !slave_phase[0] && (wr_data > s.limit[0]);
    endsequence

    sequence SEQ_SLEW_RD;
        rd_en && (cmd_code == `CMD_SLEW);
    endsequence

    sequence SEQ_WR_ALL_LIMIT;
        wr_en && (cmd_code == `CMD_LIMIT) && (page == `PAGE_ALL) && lim_ok[0] && lim_ok[1];
    endsequence

    AST_VIOL_WARN: assert property (SEQ_VIOL0 |=> s.warn[0] && status_vout[`STS_VOUT_WARN_BIT]) else $error("no warn");
    AST_VIOL_NOA: assert property (SEQ_VIOL0 |=> status_byte[`STS_BYTE_NOA_BIT]) else $error("no summary bit");
    AST_VIOL_WORD: assert property (SEQ_VIOL0 |=> status_word[`STS_WORD_VOUT_BIT]) else $error("no word bit");
    AST_VIOL_ALERT: assert property ((SEQ_VIOL0 and !alert_mask[0]) |=> !alert_n) else $error("alert missing");
    AST_VIOL_KEEP: assert property (SEQ_VIOL0 |=> $stable(s.target[0])) else $error("setpoint taken");
    AST_NO_VIOL_SET: assert property ((!$past(|viol) && $rose(s.noa)) |-> 1'b0) else $error("spurious flag");
    AST_PAGE_CH2: assert property ((wr_en && (cmd_code == `CMD_LIMIT) && (page == `PAGE_CH2) && lim_ok[1])
        |=> (s.limit[1] == $past(wr_data)) && $stable(s.limit[0])) else $error("page 1 write wrong");
    AST_PAGE_ALL: assert property (SEQ_WR_ALL_LIMIT |=> (s.limit[0] == $past(wr_data))
        && (s.limit[1] == $past(wr_data))) else $error("broadcast write wrong");
    AST_SLAVE_QUIET: assert property ((sp_wr[0] && slave_phase[0] && !s.warn[0]) |=> !s.warn[0]
        && (s.target[0] == $past(wr_data))) else $error("slave write misbehaved");
    AST_SLEW_RSVD: assert property (SEQ_SLEW_RD |=> rd_valid && (rd_data[15:3] == 13'h0000)) else $error("reserved bits");
    AST_VID_RANGE: assert property ((is_vid && wr_en && (cmd_code == `CMD_LIMIT) && (wr_data < `VID_LIMIT_MIN))
        |=> $stable(s.limit)) else $error("vid limit taken");
    AST_FMT_ONLY: assert property ((wr_en && (cmd_code == `CMD_FMT) && !fmt_ok) |=> $stable(s.fmt)) else $error("bad format");
    AST_CLEAR: assert property ((clr && !(|viol)) |=> !s.noa && !s.vout_sum && alert_n) else $error("clear failed");

endmodule

/* vlsr_host.sv */
`timescale 1ns/1ps
module vlsr_host (
    input wire logic sys_clk, // System clock
    output logic [7:0] cmd_code, // Command code
    output logic [7:0] page, // Page value
    output logic wr_en, // Write strobe
    output logic [15:0] wr_data, // Write data
    output logic rd_en, // Read strobe
    input wire logic [15:0] rd_data, // Read data
    input wire logic rd_valid // Read data valid
);
    initial begin
        cmd_code = 8'h00;
        page = 8'h00;
        wr_en = 1'b0;
        wr_data = 16'h0000;
        rd_en = 1'b0;
    end

    // ------------------------------------------------------------
    // Bus cycles
    // ------------------------------------------------------------
    // whole word, page select
    task automatic wr(input logic [7:0] c, input logic [7:0] p, input logic [15:0] d);
        @(negedge sys_clk);
        cmd_code = c;
        page = p;
        wr_data = d;
        wr_en = 1'b1;
        @(negedge sys_clk);
        wr_en = 1'b0;
        cmd_code = ~c;
        wr_data = ~d;
    endtask

    task automatic rd(input logic [7:0] c, input logic [7:0] p, output logic v, output logic [15:0] d);
        @(negedge sys_clk);
        cmd_code = c;
        page = p;
        rd_en = 1'b1;
        @(negedge sys_clk);
        rd_en = 1'b0;
        cmd_code = ~c;
        v = rd_valid;
        d = rd_data;
    endtask
endmodule

/* tb_vlsr_regs.sv */
`timescale 1ns/1ps
`include "vlsr_params.svh"
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin mismatches++; $display("[FAIL] %0t got %h exp %h", $time, a, b); end end
module tb_vlsr_regs;
    import vlsr_pkg::*;
    logic sys_clk, rstn, wr_en, rd_en, rd_valid, alert_n;
    logic [7:0] cmd_code, page, status_byte;
    logic [15:0] wr_data, rd_data, status_word, status_vout;
    logic [5:0] scale_mant;
    logic [1:0] slave_phase, alert_mask, ramp_busy, output_off;
    logic [31:0] vout_level;
    int mismatches = 0;
    int cmp_count = 0;
    int lim[2];
    int lo[3] = '{307, 614, 1229};
    int hi[3] = '{768, 1536, 3072};
    logic [2:0] sm[3] = '{3'h4, 3'h2, 3'h1};

    vlsr_regs u_dut (.sys_clk(sys_clk), .rstn(rstn), .cmd_code(cmd_code), .page(page), .wr_en(wr_en),
        .wr_data(wr_data), .rd_en(rd_en), .rd_data(rd_data), .rd_valid(rd_valid), .scale_mant(scale_mant),
        .slave_phase(slave_phase), .alert_mask(alert_mask), .status_byte(status_byte),
        .status_word(status_word), .status_vout(status_vout), .alert_n(alert_n), .vout_level(vout_level),
        .ramp_busy(ramp_busy), .output_off(output_off));
    vlsr_host u_host (.sys_clk(sys_clk), .cmd_code(cmd_code), .page(page), .wr_en(wr_en), .wr_data(wr_data),
        .rd_en(rd_en), .rd_data(rd_data), .rd_valid(rd_valid));

    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic rd_chk(input logic [7:0] c, input logic [7:0] p, input logic [15:0] e);
        logic v;
        logic [15:0] d;
        u_host.rd(c, p, v, d);
        `CHK(v, 1'b1)
        `CHK(d, e)
    endtask

    task automatic st_chk(input logic f, input logic [1:0] w, input logic a);
        `CHK(status_byte[`STS_BYTE_NOA_BIT], f)
        `CHK(status_word[`STS_WORD_VOUT_BIT], f)
        `CHK(status_word[7:0], {7'h00, f})
        `CHK({status_vout[11], status_vout[3]}, w)
        `CHK(alert_n, ~a)
    endtask

    task automatic wait_busy(input int ch, input logic b, input int n);
        int k;
        k = 0;
        while (ramp_busy[ch] !== b && k < n) begin
            @(negedge sys_clk);
            k++;
        end
        if (k >= n) begin
            mismatches++;
            $display("[FAIL] %0t ramp wait got %h exp %h", $time, ramp_busy[ch], b);
        end
    endtask

    task automatic complete_run();
        $display("Comparisons %0d, mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    initial begin
        #(95000 * 10);
        mismatches++;
        complete_run();
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        logic [15:0] d;
        int v;
        rstn = 1'b0;
        scale_mant = 6'h24;
        slave_phase = 2'b00;
        alert_mask = 2'b00;
        void'($urandom(14));
        repeat (8) @(posedge sys_clk);
        @(negedge sys_clk);
        rstn = 1'b1;
        lim = '{16'h0300, 16'h0300};
        rd_chk(`CMD_LIMIT, `PAGE_CH1, `LIMIT_RST_LIN);
        rd_chk(`CMD_LIMIT, `PAGE_CH2, `LIMIT_RST_LIN);
        rd_chk(`CMD_SLEW, `PAGE_CH2, `SLEW_RST);
        rd_chk(`CMD_FMT, `PAGE_CH1, {8'h00, `FMT_LINEAR});
        st_chk(1'b0, 2'b00, 1'b0);
        `CHK(vout_level, {`SETPT_RST_LIN, `SETPT_RST_LIN})
        // Every slew code on ch2, junk in reserved bits
        for (int c = 0; c < 8; c++) begin
            d = {16'($urandom) & 16'hfff8} | 16'(c);
            u_host.wr(`CMD_SLEW, `PAGE_CH2, d);
            rd_chk(`CMD_SLEW, `PAGE_CH2, 16'(c));
        end
        rd_chk(`CMD_SLEW, `PAGE_CH1, `SLEW_RST);
        // Limit bounds per scale factor on ch1
        for (int s = 0; s < 3; s++) begin
            scale_mant = {3'h4, sm[s]};
            for (int k = 0; k < 5; k++) begin
                v = (k == 0) ? lo[s] - 1 : (k == 1) ? lo[s] : (k == 2) ? hi[s] : (k == 3) ? hi[s] + 1
                    : lo[s] + int'($urandom % (hi[s] - lo[s]));
                if (v >= lo[s] && v <= hi[s]) begin
                    lim[0] = v;
                end
                u_host.wr(`CMD_LIMIT, `PAGE_CH1, 16'(v));
                rd_chk(`CMD_LIMIT, `PAGE_CH1, 16'(lim[0]));
            end
        end
        scale_mant = 6'h24;
        u_host.wr(`CMD_LIMIT, `PAGE_ALL, 16'h0200);
        rd_chk(`CMD_LIMIT, `PAGE_CH1, 16'h0200);
        rd_chk(`CMD_LIMIT, `PAGE_CH2, 16'h0200);
        // Setpoint above limit on ch1, then on ch2 with alert masked and as slave phase
        u_host.wr(`CMD_SETPT, `PAGE_CH1, 16'h0201);
        st_chk(1'b1, 2'b01, 1'b1);
        `CHK(vout_level[15:0], `SETPT_RST_LIN)
        `CHK(ramp_busy, 2'b00)
        u_host.wr(`CMD_CLEAR, `PAGE_CH1, 16'h0000);
        st_chk(1'b0, 2'b00, 1'b0);
        alert_mask = 2'b10;
        u_host.wr(`CMD_SETPT, `PAGE_CH2, 16'h0300);
        st_chk(1'b1, 2'b10, 1'b0);
        u_host.wr(`CMD_CLEAR, `PAGE_CH1, 16'h0000);
        alert_mask = 2'b00;
        slave_phase = 2'b10;
        u_host.wr(`CMD_SETPT, `PAGE_CH2, 16'h0300);
        st_chk(1'b0, 2'b00, 1'b0);
        `CHK(ramp_busy, 2'b00)
        slave_phase = 2'b00;
        // Ramp two codes at fastest slew
        u_host.wr(`CMD_SLEW, `PAGE_CH1, 16'h0007);
        u_host.wr(`CMD_SETPT, `PAGE_CH1, 16'h0135);
        wait_busy(0, 1'b1, 4);
        repeat (50) @(negedge sys_clk);
        `CHK(vout_level[15:0] < 16'h0135, 1'b1)
        `CHK(ramp_busy[0], 1'b1)
        wait_busy(0, 1'b0, 600);
        `CHK(vout_level[15:0], 16'h0135)
        // Voltage-ID format
        u_host.wr(`CMD_FMT, `PAGE_CH1, {8'h00, `FMT_VID});
        u_host.wr(`CMD_FMT, `PAGE_CH1, 16'h0030);
        rd_chk(`CMD_FMT, `PAGE_CH1, {8'h00, `FMT_VID});
        rd_chk(`CMD_LIMIT, `PAGE_CH2, `LIMIT_RST_VID);
        u_host.wr(`CMD_LIMIT, `PAGE_CH1, 16'h0046);
        rd_chk(`CMD_LIMIT, `PAGE_CH1, `LIMIT_RST_VID);
        u_host.wr(`CMD_LIMIT, `PAGE_CH1, `VID_LIMIT_MIN);
        rd_chk(`CMD_LIMIT, `PAGE_CH1, `VID_LIMIT_MIN);
        wait_busy(0, 1'b0, 65000);
        `CHK(vout_level[15:0], `SETPT_RST_VID)
        u_host.wr(`CMD_SETPT, `PAGE_CH1, 16'h0000);
        wait_busy(0, 1'b1, 4);
        wait_busy(0, 1'b0, 25000);
        `CHK(vout_level[15:0], 16'h0000)
        `CHK(output_off, 2'b01)
        complete_run();
    end
endmodule
